// ===== hw/machine_status_priv_stack.sv
// Purpose: Hart identity, machine status word, upper half and privilege stack
// Assumes: Trap and return requests come from the hart's own pipeline
// Notes:   Trap beats return, return beats a register write in the same cycle
//
// Overview of operation
// - Read-only hart identity register, word wide
// - Identity unique per hart, one hart is zero
// - Status word read/write, dirty summary on top
// - Upper status register only for 32-bit words
// - Upper bits 30:4 mirror status 62:36
// - Supervisor status is a masked status view
// - Machine enable bit 3, supervisor bit 1
// - Current mode interrupts follow its enable
// - Lower mode interrupts always disabled
// - Higher mode interrupts always enabled
// - No supervisor: its enables read zero
// - Machine previous mode 12:11, supervisor bit 8
// - Trap entry stacks enable and previous mode
// - Each return instruction returns its own mode
// - Return restores enable, mode; resets stack entry
// - Previous mode fields hold only legal modes
// - Two-mode parts need one machine mode bit
`timescale 1ns/100ps
module machine_status_priv_stack
   import machine_status_pkg::*;
#(
   parameter int                     MACHINE_WORD_WIDTH = 64,
   parameter logic [FULL_WIDTH-1:0]  HART_IDENTITY      = 64'h0000000000000000,
   parameter bit                     SUPERVISOR_IMPL    = 1'b1,
   parameter bit                     USER_IMPL          = 1'b1
) (
   input  wire logic                           i_clk,
   input  wire logic                           i_reset,
   input  wire logic [11:0]                    i_csr_addr,
   input  wire logic                           i_csr_read,
   input  wire logic                           i_csr_write,
   input  wire logic [MACHINE_WORD_WIDTH-1:0]  i_csr_wdata,
   input  wire trap_req_type                   i_trap,
   output logic [MACHINE_WORD_WIDTH-1:0]       o_csr_rdata,
   output logic                                o_csr_fault,
   output priv_type                            o_priv,
   output status_fields_type                   o_status,
   output logic                                o_irq_en_machine,
   output logic                                o_irq_en_supervisor
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   localparam priv_type LEAST_PRIV = USER_IMPL ? PRIV_USER : PRIV_MACHINE;
   localparam bit       WIDE_WORD  = (MACHINE_WORD_WIDTH == FULL_WIDTH);

   priv_type                 priv_r;
   priv_type                 priv_nxt;
   status_fields_type        fields_r;
   status_fields_type        fields_nxt;
   logic [UPPER_WIDTH-1:0]   upper_r;
   logic [UPPER_WIDTH-1:0]   upper_nxt;
   logic [FULL_WIDTH-1:0]    wdata_full;
   logic [FULL_WIDTH-1:0]    status_full;
   logic [MACHINE_WORD_WIDTH-1:0] read_word;
   logic                     read_hit;
   logic                     write_ro;
   priv_type                 mpp_legal;
   logic                     gate_machine;
   logic                     gate_supervisor;
   logic                     trap_to_sup;
   logic                     do_machine_trap_return;
   logic                     do_supervisor_trap_return;
   logic                     wr_status;
   logic                     wr_upper;
   logic                     wr_sup;

   assign wdata_full  = FULL_WIDTH'(i_csr_wdata);
   // A supervisor trap on a part without that mode lands in machine mode
   assign trap_to_sup = i_trap.to_supervisor && SUPERVISOR_IMPL;
   assign do_machine_trap_return     = !i_trap.take && i_trap.machine_trap_return;
   assign do_supervisor_trap_return     = !i_trap.take && !i_trap.machine_trap_return
                        && i_trap.supervisor_trap_return && SUPERVISOR_IMPL;
   assign wr_status   = i_csr_write && (i_csr_addr == ADDR_STATUS_WORD);
   assign wr_upper    = i_csr_write && (i_csr_addr == ADDR_STATUS_UPPER) && !WIDE_WORD;
   assign wr_sup      = i_csr_write && (i_csr_addr == ADDR_SUPERVISOR_STATUS)
                        && SUPERVISOR_IMPL;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers
   mode_field_legal #(
      .SUPERVISOR_IMPL (SUPERVISOR_IMPL),
      .USER_IMPL       (USER_IMPL)
   ) u_mpp_legal (
      .i_requested (priv_type'(wdata_full[POS_MACH_PP_HI:POS_MACH_PP_LO])),
      .o_legal     (mpp_legal)
   );

   irq_global_gate u_gate (
      .i_priv          (priv_r),
      .i_machine_ie    (fields_r.machine_global_irq_en),
      .i_supervisor_ie (fields_r.supervisor_global_irq_en),
      .o_machine_en    (gate_machine),
      .o_supervisor_en (gate_supervisor)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next state of the privilege stack
   always_comb begin
      priv_nxt   = priv_r;
      fields_nxt = fields_r;
      upper_nxt  = upper_r;
      if (i_trap.take && trap_to_sup) begin
         fields_nxt.supervisor_prev_irq_en   = fields_r.supervisor_global_irq_en;
         fields_nxt.supervisor_global_irq_en = 1'b0;
         fields_nxt.supervisor_prev_priv     = (priv_r == PRIV_SUPERVISOR);
         priv_nxt                            = PRIV_SUPERVISOR;
      end else if (i_trap.take) begin
         fields_nxt.machine_prev_irq_en   = fields_r.machine_global_irq_en;
         fields_nxt.machine_global_irq_en = 1'b0;
         fields_nxt.machine_prev_priv     = priv_r;
         priv_nxt                         = PRIV_MACHINE;
      end else if (do_machine_trap_return) begin
         fields_nxt.machine_global_irq_en = fields_r.machine_prev_irq_en;
         fields_nxt.machine_prev_irq_en   = 1'b1;
         fields_nxt.machine_prev_priv     = LEAST_PRIV;
         priv_nxt                         = fields_r.machine_prev_priv;
         if (fields_r.machine_prev_priv != PRIV_MACHINE) begin
            fields_nxt.load_store_priv_override = 1'b0;
         end
      end else if (do_supervisor_trap_return) begin
         fields_nxt.supervisor_global_irq_en = fields_r.supervisor_prev_irq_en;
         fields_nxt.supervisor_prev_irq_en   = 1'b1;
         fields_nxt.supervisor_prev_priv     = 1'b0;
         priv_nxt = fields_r.supervisor_prev_priv ? PRIV_SUPERVISOR : PRIV_USER;
         fields_nxt.load_store_priv_override = 1'b0;
      end else if (wr_status) begin
         fields_nxt.machine_global_irq_en    = wdata_full[POS_MACH_IE];
         fields_nxt.machine_prev_irq_en      = wdata_full[POS_MACH_PIE];
         fields_nxt.machine_prev_priv        = mpp_legal;
         fields_nxt.supervisor_global_irq_en = wdata_full[POS_SUP_IE] && SUPERVISOR_IMPL;
         fields_nxt.supervisor_prev_irq_en   = wdata_full[POS_SUP_PIE] && SUPERVISOR_IMPL;
         fields_nxt.supervisor_prev_priv     = wdata_full[POS_SUP_PP] && SUPERVISOR_IMPL;
         fields_nxt.load_store_priv_override = wdata_full[POS_LS_OVERRIDE] && USER_IMPL;
         if (WIDE_WORD) begin
            upper_nxt = wdata_full[UPPER_FIELD_HI:UPPER_FIELD_LO];
         end
      end else if (wr_upper) begin
         upper_nxt = wdata_full[UPPER_REG_HI:UPPER_REG_LO];
      end else if (wr_sup) begin
         // Supervisor view reaches only its own fields
         fields_nxt.supervisor_global_irq_en = wdata_full[POS_SUP_IE];
         fields_nxt.supervisor_prev_irq_en   = wdata_full[POS_SUP_PIE];
         fields_nxt.supervisor_prev_priv     = wdata_full[POS_SUP_PP];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State registers
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         priv_r <= PRIV_MACHINE;
      end else begin
         priv_r <= priv_nxt;
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         fields_r <= STATUS_RESET;
      end else begin
         fields_r <= fields_nxt;
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         upper_r <= UPPER_RESET;
      end else begin
         upper_r <= upper_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read side
   always_comb begin
      status_full = '0;
      status_full[POS_SUP_IE]      = fields_r.supervisor_global_irq_en;
      status_full[POS_MACH_IE]     = fields_r.machine_global_irq_en;
      status_full[POS_SUP_PIE]     = fields_r.supervisor_prev_irq_en;
      status_full[POS_MACH_PIE]    = fields_r.machine_prev_irq_en;
      status_full[POS_SUP_PP]      = fields_r.supervisor_prev_priv;
      status_full[POS_MACH_PP_HI:POS_MACH_PP_LO] = fields_r.machine_prev_priv;
      status_full[POS_LS_OVERRIDE] = fields_r.load_store_priv_override;
      status_full[UPPER_FIELD_HI:UPPER_FIELD_LO] = upper_r;
      read_word = '0;
      read_hit  = 1'b1;
      write_ro  = 1'b0;
      case (i_csr_addr)
         ADDR_HART_IDENTITY: begin
            // Uniqueness is set per instance by the integrator
            read_word = HART_IDENTITY[MACHINE_WORD_WIDTH-1:0];
            write_ro  = 1'b1;
         end
         ADDR_STATUS_WORD: begin
            // Narrow word keeps the stack fields; its upper half has its own register
            read_word = status_full[MACHINE_WORD_WIDTH-1:0];
            read_word[MACHINE_WORD_WIDTH-1] = DIRTY_SUMMARY_VALUE;
         end
         ADDR_STATUS_UPPER: begin
            read_hit = !WIDE_WORD;
            if (!WIDE_WORD) begin
               read_word[UPPER_REG_HI:UPPER_REG_LO] = upper_r;
            end
         end
         ADDR_SUPERVISOR_STATUS: begin
            read_hit = SUPERVISOR_IMPL;
            read_word[POS_SUP_IE]  = fields_r.supervisor_global_irq_en;
            read_word[POS_SUP_PIE] = fields_r.supervisor_prev_irq_en;
            read_word[POS_SUP_PP]  = fields_r.supervisor_prev_priv;
         end
         default: read_hit = 1'b0;
      endcase
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_csr_rdata <= '0;
      end else if (i_csr_read && read_hit) begin
         o_csr_rdata <= read_word;
      end else begin
         o_csr_rdata <= '0;
      end
   end

   // Flags accesses to absent registers and writes to read-only ones
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_csr_fault <= 1'b0;
      end else begin
         o_csr_fault <= ((i_csr_read || i_csr_write) && !read_hit)
                        || (i_csr_write && write_ro);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_irq_en_machine    <= 1'b0;
         o_irq_en_supervisor <= 1'b0;
      end else begin
         o_irq_en_machine    <= gate_machine;
         o_irq_en_supervisor <= gate_supervisor;
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_priv   <= PRIV_MACHINE;
         o_status <= STATUS_RESET;
      end else begin
         o_priv   <= priv_nxt;
         o_status <= fields_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);

   sequence s_trap_machine;
      i_trap.take && !trap_to_sup;
   endsequence

   sequence s_machine_stacked;
      !fields_r.machine_global_irq_en && priv_r == PRIV_MACHINE;
   endsequence

   property p_trap_machine;
      s_trap_machine |=> s_machine_stacked
         and fields_r.machine_prev_irq_en == $past(fields_r.machine_global_irq_en)
         and fields_r.machine_prev_priv == $past(priv_r);
   endproperty
   a_trap_machine: assert property (p_trap_machine) else $error("machine trap stack wrong");

   property p_trap_super;
      (i_trap.take && trap_to_sup) |=> !fields_r.supervisor_global_irq_en
         && priv_r == PRIV_SUPERVISOR
         && fields_r.supervisor_prev_irq_en == $past(fields_r.supervisor_global_irq_en);
   endproperty
   a_trap_super: assert property (p_trap_super) else $error("supervisor trap stack wrong");

   property p_machine_trap_return;
      do_machine_trap_return |=> priv_r == $past(fields_r.machine_prev_priv)
         && fields_r.machine_global_irq_en == $past(fields_r.machine_prev_irq_en)
         && fields_r.machine_prev_irq_en && fields_r.machine_prev_priv == LEAST_PRIV;
   endproperty
   a_machine_trap_return: assert property (p_machine_trap_return) else $error("machine return wrong");

   property p_supervisor_trap_return;
      do_supervisor_trap_return |=> priv_r != PRIV_MACHINE && fields_r.supervisor_prev_irq_en
         && !fields_r.supervisor_prev_priv && !fields_r.load_store_priv_override;
   endproperty
   a_supervisor_trap_return: assert property (p_supervisor_trap_return) else $error("supervisor return wrong");

   property p_lower_off;
      priv_r == PRIV_MACHINE |=> !o_irq_en_supervisor;
   endproperty
   a_lower_off: assert property (p_lower_off) else $error("lower mode irq enabled");

   property p_higher_on;
      priv_r == PRIV_USER |=> o_irq_en_machine && o_irq_en_supervisor;
   endproperty
   a_higher_on: assert property (p_higher_on) else $error("higher mode irq masked");

   property p_same_mode;
      priv_r == PRIV_MACHINE |=> o_irq_en_machine == $past(fields_r.machine_global_irq_en);
   endproperty
   a_same_mode: assert property (p_same_mode) else $error("current mode gate wrong");

   property p_mpp_legal;
      fields_r.machine_prev_priv != PRIV_RESERVED;
   endproperty
   a_mpp_legal: assert property (p_mpp_legal) else $error("illegal previous mode");

   property p_hart_id;
      (i_csr_read && i_csr_addr == ADDR_HART_IDENTITY)
         |=> o_csr_rdata == HART_IDENTITY[MACHINE_WORD_WIDTH-1:0];
   endproperty
   a_hart_id: assert property (p_hart_id) else $error("hart identity read wrong");

   property p_no_super;
      !SUPERVISOR_IMPL |-> !fields_r.supervisor_global_irq_en
         && !fields_r.supervisor_prev_irq_en && !fields_r.supervisor_prev_priv;
   endproperty
   a_no_super: assert property (p_no_super) else $error("absent supervisor bits set");

   property p_dirty_read;
      (i_csr_read && i_csr_addr == ADDR_STATUS_WORD)
         |=> o_csr_rdata[MACHINE_WORD_WIDTH-1] == DIRTY_SUMMARY_VALUE;
   endproperty
   a_dirty_read: assert property (p_dirty_read) else $error("dirty summary wrong");

   property p_enable_write;
      (wr_status && !i_trap.take && !do_machine_trap_return && !do_supervisor_trap_return)
         |=> fields_r.machine_global_irq_en == $past(wdata_full[POS_MACH_IE]);
   endproperty
   a_enable_write: assert property (p_enable_write) else $error("enable write lost");

   property p_upper_write;
      (wr_upper && !i_trap.take && !do_machine_trap_return && !do_supervisor_trap_return)
         |=> upper_r == $past(wdata_full[UPPER_REG_HI:UPPER_REG_LO]);
   endproperty
   a_upper_write: assert property (p_upper_write) else $error("upper write lost");

endmodule // machine_status_priv_stack

// ===== hw/machine_status_pkg.sv
// Purpose: Shared constants and types for the machine status block
// Assumes: Control-register addresses are 12 bits wide
// Notes:   Bit positions refer to the 64-bit view of the status word, except UPPER_REG_LO and UPPER_REG_HI, which index the upper register
package machine_status_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register addresses
   localparam logic [11:0] ADDR_HART_IDENTITY     = 12'hF14;
   localparam logic [11:0] ADDR_STATUS_WORD       = 12'h300;
   localparam logic [11:0] ADDR_STATUS_UPPER      = 12'h310;
   localparam logic [11:0] ADDR_SUPERVISOR_STATUS = 12'h100;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int FULL_WIDTH      = 64;
   localparam int HALF_WIDTH      = 32;
   localparam int POS_SUP_IE      = 1;
   localparam int POS_MACH_IE     = 3;
   localparam int POS_SUP_PIE     = 5;
   localparam int POS_MACH_PIE    = 7;
   localparam int POS_SUP_PP      = 8;
   localparam int POS_MACH_PP_LO  = 11;
   localparam int POS_MACH_PP_HI  = 12;
   localparam int POS_LS_OVERRIDE = 17;
   localparam int UPPER_FIELD_LO  = 36;
   localparam int UPPER_FIELD_HI  = 62;
   localparam int UPPER_REG_LO    = 4;
   localparam int UPPER_REG_HI    = 30;
   localparam int UPPER_WIDTH     = UPPER_FIELD_HI - UPPER_FIELD_LO + 1;

   localparam logic                   DIRTY_SUMMARY_VALUE = 1'b0;
   localparam logic [UPPER_WIDTH-1:0] UPPER_RESET         = 27'h0000000;

   ////////////////////////////////////////////////////////////////////////////
   // Privilege encodings
   typedef enum logic [1:0] {
      PRIV_USER       = 2'b00,
      PRIV_SUPERVISOR = 2'b01,
      PRIV_RESERVED   = 2'b10,
      PRIV_MACHINE    = 2'b11
   } priv_type;

   ////////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      logic take;
      logic to_supervisor;
      logic machine_trap_return;
      logic supervisor_trap_return;
   } trap_req_type;

   typedef struct packed {
      logic     load_store_priv_override;
      priv_type machine_prev_priv;
      logic     supervisor_prev_priv;
      logic     machine_prev_irq_en;
      logic     supervisor_prev_irq_en;
      logic     machine_global_irq_en;
      logic     supervisor_global_irq_en;
   } status_fields_type;

   localparam status_fields_type STATUS_RESET = '{
      load_store_priv_override : 1'b0,
      machine_prev_priv        : PRIV_MACHINE,
      supervisor_prev_priv     : 1'b0,
      machine_prev_irq_en      : 1'b0,
      supervisor_prev_irq_en   : 1'b0,
      machine_global_irq_en    : 1'b0,
      supervisor_global_irq_en : 1'b0
   };

endpackage

// ===== hw/mode_field_legal.sv
// Purpose: Maps a requested previous-privilege value to a legal one
// Assumes: Field belongs to machine mode, so machine is always legal
// Notes:   Illegal requests fall back to machine mode
`timescale 1ns/100ps
module mode_field_legal
   import machine_status_pkg::*;
#(
   parameter bit SUPERVISOR_IMPL = 1'b1,
   parameter bit USER_IMPL       = 1'b1
) (
   input  wire priv_type i_requested,
   output priv_type      o_legal
);

   always_comb begin
      case (i_requested)
         PRIV_MACHINE:    o_legal = PRIV_MACHINE;
         PRIV_SUPERVISOR: o_legal = SUPERVISOR_IMPL ? PRIV_SUPERVISOR : PRIV_MACHINE;
         // Two-mode parts only ever see 00 or 11, so one storage bit would do
         PRIV_USER:       o_legal = USER_IMPL ? PRIV_USER : PRIV_MACHINE;
         default:         o_legal = PRIV_MACHINE;
      endcase
   end

endmodule // mode_field_legal

// ===== hw/irq_global_gate.sv
// Purpose: Global interrupt enable per target mode from current privilege
// Assumes: Per-interrupt enables are applied downstream
// Notes:   Purely combinational; the caller registers the results
`timescale 1ns/100ps
module irq_global_gate
   import machine_status_pkg::*;
(
   input  wire priv_type i_priv,
   input  wire logic     i_machine_ie,
   input  wire logic     i_supervisor_ie,
   output logic          o_machine_en,
   output logic          o_supervisor_en
);

   always_comb begin
      // Machine is never below the current mode
      o_machine_en = (i_priv == PRIV_MACHINE) ? i_machine_ie : 1'b1;
      case (i_priv)
         PRIV_USER:       o_supervisor_en = 1'b1;
         PRIV_SUPERVISOR: o_supervisor_en = i_supervisor_ie;
         default:         o_supervisor_en = 1'b0;
      endcase
   end

endmodule // irq_global_gate

// ===== tb/test_machine_status_priv_stack.sv
// Purpose: Self-checking bench for the machine status block
// Assumes: Main instance 64-bit with all modes; twin 32-bit, machine only, identity 1
// Notes:   Shadow model of stack fields and mode; random ops from an LFSR
`timescale 1ns/100ps
module test_machine_status_priv_stack
   import machine_status_pkg::*;
();
   logic              i_clk = 1'b0;
   logic              i_reset;
   logic [11:0]       i_csr_addr = 12'h000;
   logic              i_csr_read = 1'b0;
   logic              i_csr_write = 1'b0;
   logic [63:0]       i_csr_wdata = 64'h0;
   trap_req_type      i_trap = '0;
   logic [63:0]       o_csr_rdata;
   logic              o_csr_fault;
   priv_type          o_priv;
   status_fields_type o_status;
   logic              o_irq_en_machine;
   logic              o_irq_en_supervisor;
   status_fields_type mdl;
   priv_type          mpriv;
   logic [26:0]       mupper;
   logic [31:0]       alt_rdata;
   int                fail_count = 0;
   int                samples_checked = 0;
   int                cycles = 0;
   logic [31:0]       seed = 32'h0001538D;

   always #4 i_clk = ~i_clk;

   machine_status_priv_stack #(.MACHINE_WORD_WIDTH(64)) dut_u (
      .i_clk(i_clk), .i_reset(i_reset), .i_csr_addr(i_csr_addr),
      .i_csr_read(i_csr_read), .i_csr_write(i_csr_write), .i_csr_wdata(i_csr_wdata),
      .i_trap(i_trap), .o_csr_rdata(o_csr_rdata), .o_csr_fault(o_csr_fault),
      .o_priv(o_priv), .o_status(o_status), .o_irq_en_machine(o_irq_en_machine),
      .o_irq_en_supervisor(o_irq_en_supervisor));

   // Narrow twin with machine mode only, identity 1
   machine_status_priv_stack #(.MACHINE_WORD_WIDTH(32), .HART_IDENTITY(64'h1),
      .SUPERVISOR_IMPL(1'b0), .USER_IMPL(1'b0)) alt_u (
      .i_clk(i_clk), .i_reset(i_reset), .i_csr_addr(i_csr_addr),
      .i_csr_read(i_csr_read), .i_csr_write(i_csr_write), .i_csr_wdata(i_csr_wdata[31:0]),
      .i_trap(i_trap), .o_csr_rdata(alt_rdata), .o_csr_fault(), .o_priv(), .o_status(),
      .o_irq_en_machine(), .o_irq_en_supervisor());

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Stack fields only; callers add the upper storage bits
   function automatic logic [63:0] word_of(input status_fields_type s);
      logic [63:0] w;
      w = 64'h0;
      w[1] = s.supervisor_global_irq_en;
      w[3] = s.machine_global_irq_en;
      w[5] = s.supervisor_prev_irq_en;
      w[7] = s.machine_prev_irq_en;
      w[8] = s.supervisor_prev_priv;
      w[12:11] = s.machine_prev_priv;
      w[17] = s.load_store_priv_override;
      return w;
   endfunction

   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic give_verdict();
      $display("Checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         give_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Each task sets the request signals it drives once, just after an edge; idle and do_return leave address and write data as they were
   task automatic step();
      @(posedge i_clk);
      #1;
   endtask

   task automatic idle();
      i_csr_read = 1'b0;
      i_csr_write = 1'b0;
      i_trap = '0;
      step();
   endtask

   task automatic csr(input logic wr, input logic [11:0] a, input logic [63:0] d);
      i_trap = '0;
      i_csr_addr = a;
      i_csr_write = wr;
      i_csr_read = ~wr;
      i_csr_wdata = d;
      step();
   endtask

   task automatic model_write(input logic [63:0] w);
      mdl.supervisor_global_irq_en = w[1];
      mdl.machine_global_irq_en = w[3];
      mdl.supervisor_prev_irq_en = w[5];
      mdl.machine_prev_irq_en = w[7];
      mdl.supervisor_prev_priv = w[8];
      mdl.machine_prev_priv = (w[12:11] == 2'b10) ? PRIV_MACHINE : priv_type'(w[12:11]);
      mdl.load_store_priv_override = w[17];
      mupper = w[62:36];
   endtask

   task automatic do_trap(input logic to_s, input logic with_write);
      i_trap = {1'b1, to_s, 2'b00};
      i_csr_read = 1'b0;
      i_csr_write = with_write;
      i_csr_addr = 12'h300;
      i_csr_wdata = 64'hFFFF_FFFF_FFFF_FFFF;
      if (to_s) begin
         mdl.supervisor_prev_irq_en = mdl.supervisor_global_irq_en;
         mdl.supervisor_global_irq_en = 1'b0;
         mdl.supervisor_prev_priv = (mpriv == PRIV_SUPERVISOR);
         mpriv = PRIV_SUPERVISOR;
      end else begin
         mdl.machine_prev_irq_en = mdl.machine_global_irq_en;
         mdl.machine_global_irq_en = 1'b0;
         mdl.machine_prev_priv = mpriv;
         mpriv = PRIV_MACHINE;
      end
      step();
   endtask

   task automatic do_return();
      i_csr_read = 1'b0;
      i_csr_write = 1'b0;
      if (mpriv == PRIV_MACHINE) begin
         i_trap = 4'b0010;
         mpriv = mdl.machine_prev_priv;
         mdl.machine_global_irq_en = mdl.machine_prev_irq_en;
         mdl.machine_prev_irq_en = 1'b1;
         mdl.machine_prev_priv = PRIV_USER;
         if (mpriv != PRIV_MACHINE) mdl.load_store_priv_override = 1'b0;
      end else begin
         i_trap = 4'b0001;
         mpriv = mdl.supervisor_prev_priv ? PRIV_SUPERVISOR : PRIV_USER;
         mdl.supervisor_global_irq_en = mdl.supervisor_prev_irq_en;
         mdl.supervisor_prev_irq_en = 1'b1;
         mdl.supervisor_prev_priv = 1'b0;
         mdl.load_store_priv_override = 1'b0;
      end
      step();
   endtask

   task automatic verify();
      check("priv", 64'(o_priv), 64'(mpriv));
      check("stack", 64'(o_status), 64'(mdl));
      idle();
      check("irq machine", 64'(o_irq_en_machine),
            64'(mpriv != PRIV_MACHINE || mdl.machine_global_irq_en));
      check("irq supervisor", 64'(o_irq_en_supervisor), 64'(mpriv == PRIV_USER ||
            (mpriv == PRIV_SUPERVISOR && mdl.supervisor_global_irq_en)));
      csr(1'b0, 12'h300, 64'h0);
      check("status read", o_csr_rdata, word_of(mdl) | {1'b0, mupper, 36'h0});
      check("alt mode field", 64'(alt_rdata & 32'h0000_1922), 64'h1800);
      csr(1'b0, 12'h100, 64'h0);
      check("view read", o_csr_rdata, word_of(mdl) & 64'h0000_0000_0000_0122);
   endtask

   task automatic apply_reset();
      i_reset = 1'b1;
      mdl = STATUS_RESET;
      mpriv = PRIV_MACHINE;
      mupper = '0;
      repeat (2) @(posedge i_clk);
      #1;
      i_reset = 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      apply_reset();
      verify();
      csr(1'b0, 12'hF14, 64'h0);
      check("identity read", {o_csr_rdata[63:1], o_csr_fault}, 64'h0);
      check("identity alt", 64'(alt_rdata), 64'h1);
      csr(1'b1, 12'hF14, 64'h1234_5678_9ABC_DEF0);
      check("identity write fault", 64'(o_csr_fault), 64'h1);
      csr(1'b1, 12'h310, 64'hFFFF_FFFF_A5A5_A5A5);
      check("upper write refused", 64'(o_csr_fault), 64'h1);
      csr(1'b0, 12'h310, 64'h0);
      check("upper absent", 64'(o_csr_fault), 64'h1);
      check("upper narrow", 64'(alt_rdata), 64'h0000_0000_25A5_A5A0);
      csr(1'b0, 12'h7C0, 64'h0);
      check("unmapped", {o_csr_rdata[63:1], o_csr_fault}, 64'h1);
      // Reserved mode code must not stick
      model_write(64'h0000_0000_0002_10AA);
      csr(1'b1, 12'h300, 64'h0000_0000_0002_10AA);
      verify();
      // Write in the trap cycle is dropped
      do_trap(1'b0, 1'b1);
      verify();
      for (int n = 0; n < 60; n++) begin
         seed = lfsr_next(seed);
         if (seed[1:0] == 2'd0) begin
            model_write({seed, ~seed});
            csr(1'b1, 12'h300, {seed, ~seed});
         end else if (seed[1:0] == 2'd1 || mpriv == PRIV_USER) begin
            do_trap(seed[2] && mpriv != PRIV_MACHINE, 1'b0);
         end else begin
            do_return();
         end
         verify();
      end
      // Mid-run reset must bring back the reset view
      apply_reset();
      verify();
      give_verdict();
   end
endmodule // test_machine_status_priv_stack
